// *** hw/epa_defs.svh ***
// Constants for the eight-stage pipeline with instruction align queue
// Notes on behaviour
// - Lines pass fetch1-3, decode, integer, access, compute1, compute2 in order.
// - Each stage takes one cycle per line unless stalled.
// - Fetch is memory driven; requests quad words while queue holds under three.
// - Align queue is a FIFO of at most five quad words.
// - Internal fetch requests four words every cycle while the queue holds under three.
// - External fetch delivers at most one quad word per two bus clocks.
// - Decode removes next whole line and routes it to units.
// - Queue computes program counter of lines; it decodes nothing.
// - Integer op computes at integer stage; memory access starts at access.
// - Integer results commit after compute2; forwarded until then.
// - Load data reaches its register only at compute2.
// - Compute ops check dependency at integer, select sources, run two cycles.
// - Compute results and flags written on edge after compute2.
// - Multiply-accumulate updates accumulator regs one cycle after compute2.
// - Same-line operands read values held before the line executes.
// - Stall inserted when a line needs an earlier result not yet ready.
// - Quad words fill next free entry; pull only when a full line exists.
// - Fetch keeps filling the queue while later stages stall.
// - Line ends at instruction whose opcode MSB is clear; one to four words.
`ifndef EPA_DEFS_SVH
`define EPA_DEFS_SVH
`define EPA_WORD_W 32
`define EPA_QUAD_W 128
`define EPA_ADDR_W 32
`define EPA_Q_DEPTH 5
`define EPA_Q_WORDS 20
`define EPA_CNT_W 5
`define EPA_FILL_LIMIT 5'h0C
`define EPA_FULL_LEVEL 5'h14
`define EPA_MAX_LINE 3'h4
`define EPA_PAR_BIT 31
`define EPA_REG_W 5
`define EPA_EXT_GAP 2'h2
`define EPA_QUAD_INC 32'h0000_0010
`define EPA_WORD_INC 32'h0000_0004
`endif

// *** hw/epa_pkg.sv ***
// Types for the eight-stage pipeline
`default_nettype none
package epa_pkg;
	typedef enum logic [1:0] {
		EPA_FS_IDLE = 2'b00,
		EPA_FS_WAIT = 2'b01,
		EPA_FS_GAP = 2'b10
	} epa_fetch_state_t;
endpackage
`default_nettype wire

// *** hw/epa_pipe.sv ***
// Eight-stage pipeline core with instruction align queue
`include "epa_defs.svh"
`default_nettype none
module epa_pipe
	import epa_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Fetch port to instruction memory
	output logic fetch_req_out,
	output logic [`EPA_ADDR_W-1:0] fetch_addr_out,
	input wire logic fetch_ext_in,
	input wire logic fetch_valid_in,
	input wire logic [`EPA_QUAD_W-1:0] fetch_data_in,
	input wire logic sclk_en_in,
	// Change of flow from sequencer
	input wire logic flow_taken_in,
	input wire logic [`EPA_ADDR_W-1:0] flow_target_in,
	// Dependency info of the decoded line, and bus grant for the access stage
	input wire logic [`EPA_REG_W-1:0] dec_src_reg_in,
	input wire logic dec_src_used_in,
	input wire logic [`EPA_REG_W-1:0] dec_dst_reg_in,
	input wire logic dec_late_in,
	input wire logic dec_mac_in,
	input wire logic acc_grant_in,
	// Line issued to execution units
	output logic line_valid_out,
	output logic [`EPA_QUAD_W-1:0] line_data_out,
	output logic [2:0] line_len_out,
	output logic [`EPA_ADDR_W-1:0] line_pc_out,
	// Stage occupancy and write-back strobes
	output logic [7:0] stage_valid_out,
	output logic stall_out,
	output logic wb_commit_out,
	output logic [`EPA_REG_W-1:0] wb_reg_out,
	output logic acc_commit_out
);
	////////////////////////////////////////////////////////////////////
	// Align queue storage
	logic [`EPA_WORD_W-1:0] q_r [0:`EPA_Q_WORDS-1];
	logic [`EPA_WORD_W-1:0] q_nxt [0:`EPA_Q_WORDS-1];
	logic [`EPA_CNT_W-1:0] cnt_r, cnt_nxt;
	logic [`EPA_ADDR_W-1:0] pc_r, pc_nxt;
	logic [`EPA_ADDR_W-1:0] faddr_r, faddr_nxt;
	epa_fetch_state_t fs_r, fs_nxt;
	logic [1:0] gap_r, gap_nxt;
	logic [1:0] out_r, out_nxt;
	logic [1:0] drop_r, drop_nxt;
	// Stage pipeline: valid per stage 0..7; dst, late, mac per stage 3..7
	logic [7:0] sv_r, sv_nxt;
	logic [`EPA_REG_W-1:0] dst_r [3:7];
	logic [`EPA_REG_W-1:0] dst_nxt [3:7];
	logic [7:3] late_r, late_nxt, mac_r, mac_nxt;
	logic mac_d_r, mac_d_nxt;
	logic [`EPA_QUAD_W-1:0] ld_r, ld_nxt;
	logic [2:0] ll_r, ll_nxt;
	logic [`EPA_ADDR_W-1:0] lpc_r, lpc_nxt;
	logic lv_r, lv_nxt;

	// Count words in the leading line, zero if incomplete
	function automatic logic [2:0] line_len(
		input logic [`EPA_CNT_W-1:0] cnt,
		input logic [`EPA_MAX_LINE-1:0] msb);
		logic [2:0] n;
		n = 3'h0;
		for (int i = `EPA_MAX_LINE - 1; i >= 0; i--) begin
			if (!msb[i] && 5'(i) < cnt) begin
				n = 3'(i + 1);
			end
		end
		return n;
	endfunction

	logic [`EPA_MAX_LINE-1:0] head_msb;
	logic [2:0] head_len;
	logic hazard, pull, accept, adv;
	always_comb begin
		for (int i = 0; i < `EPA_MAX_LINE; i++) begin
			head_msb[i] = q_r[i][`EPA_PAR_BIT];
		end
	end
	assign head_len = line_len(cnt_r, head_msb);
	// Late results (loads, compute) not ready before compute2
	always_comb begin
		hazard = 1'b0;
		for (int s = 3; s <= 6; s++) begin
			if (sv_r[s] && late_r[s] && dec_src_used_in &&
				dst_r[s] == dec_src_reg_in) begin
				hazard = 1'b1;
			end
		end
	end
	// Access stage waits for bus grant before moving on
	assign stall_out = hazard || (sv_r[5] && !acc_grant_in);
	assign adv = !stall_out;
	// Pull only a whole line, one per cycle
	assign pull = adv && head_len != 3'h0 && !flow_taken_in;
	// Refuse data from stale requests after a flush
	assign accept = fetch_valid_in && drop_r == 2'h0;

	////////////////////////////////////////////////////////////////////
	// Fetch engine, runs regardless of stalls
	logic [`EPA_CNT_W-1:0] level;
	always_comb begin
		fs_nxt = fs_r;
		gap_nxt = gap_r;
		faddr_nxt = faddr_r;
		out_nxt = out_r;
		drop_nxt = drop_r;
		fetch_req_out = 1'b0;
		// Count words in flight so the queue never overflows
		level = cnt_r + {out_r, 2'b00};
		if (fetch_valid_in) begin
			if (drop_r != 2'h0) begin
				drop_nxt = drop_r - 2'h1;
			end else begin
				out_nxt = out_r - 2'h1;
			end
		end
		case (fs_r)
			EPA_FS_IDLE: begin
				if (level < `EPA_FILL_LIMIT && !flow_taken_in) begin
					fetch_req_out = 1'b1;
					faddr_nxt = faddr_r + `EPA_QUAD_INC;
					out_nxt = out_nxt + 2'h1;
					if (fetch_ext_in) begin
						fs_nxt = EPA_FS_WAIT;
					end
				end
			end
			EPA_FS_WAIT: begin
				if (accept) begin
					fs_nxt = EPA_FS_GAP;
					gap_nxt = `EPA_EXT_GAP;
				end
			end
			EPA_FS_GAP: begin
				// Pace external lines on the bus clock enable
				if (sclk_en_in) begin
					gap_nxt = gap_r - 2'h1;
					if (gap_r == 2'h1) begin
						fs_nxt = EPA_FS_IDLE;
					end
				end
			end
			default: fs_nxt = EPA_FS_IDLE;
		endcase
		if (flow_taken_in) begin
			// Flush and restart at the target
			faddr_nxt = flow_target_in;
			drop_nxt = fetch_valid_in && drop_r == 2'h0 ?
				out_r - 2'h1 : out_nxt + drop_nxt;
			out_nxt = 2'h0;
			fs_nxt = EPA_FS_IDLE;
		end
	end
	assign fetch_addr_out = faddr_r;

	////////////////////////////////////////////////////////////////////
	// Queue shift and fill, program counter
	always_comb begin
		logic [`EPA_CNT_W-1:0] base;
		base = cnt_r;
		for (int i = 0; i < `EPA_Q_WORDS; i++) begin
			q_nxt[i] = q_r[i];
		end
		cnt_nxt = cnt_r;
		pc_nxt = pc_r;
		if (pull) begin
			for (int i = 0; i < `EPA_Q_WORDS; i++) begin
				q_nxt[i] = (i + head_len < `EPA_Q_WORDS) ?
					q_r[i + head_len] : '0;
			end
			base = cnt_r - 5'(head_len);
			pc_nxt = pc_r + {27'h0, head_len, 2'b00};
		end
		cnt_nxt = base;
		if (accept && !flow_taken_in) begin
			for (int k = 0; k < `EPA_MAX_LINE; k++) begin
				q_nxt[5'(base + 5'(k))] =
					fetch_data_in[k*`EPA_WORD_W +: `EPA_WORD_W];
			end
			cnt_nxt = base + 5'(`EPA_MAX_LINE);
		end
		if (flow_taken_in) begin
			cnt_nxt = '0;
			pc_nxt = flow_target_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Stage pipeline and write-back timing
	always_comb begin
		for (int s = 3; s <= 7; s++) begin
			dst_nxt[s] = dst_r[s];
		end
		late_nxt = late_r;
		mac_nxt = mac_r;
		sv_nxt = sv_r;
		ld_nxt = ld_r;
		ll_nxt = ll_r;
		lpc_nxt = lpc_r;
		lv_nxt = 1'b0;
		sv_nxt[2:0] = {sv_r[1:0], fetch_req_out};
		if (adv) begin
			// Stages 3..7 shift; a bubble goes in when no line
			sv_nxt[7:4] = sv_r[6:3];
			for (int s = 4; s <= 7; s++) begin
				dst_nxt[s] = dst_r[s-1];
			end
			late_nxt[7:4] = late_r[6:3];
			mac_nxt[7:4] = mac_r[6:3];
			sv_nxt[3] = pull;
			dst_nxt[3] = dec_dst_reg_in;
			late_nxt[3] = dec_late_in;
			mac_nxt[3] = dec_mac_in;
		end else begin
			// Stall bubble enters compute1; stages 3..5 hold
			sv_nxt[7] = sv_r[6];
			dst_nxt[7] = dst_r[6];
			late_nxt[7] = late_r[6];
			mac_nxt[7] = mac_r[6];
			sv_nxt[6] = 1'b0;
		end
		if (pull) begin
			lv_nxt = 1'b1;
			ll_nxt = head_len;
			lpc_nxt = pc_r;
			for (int k = 0; k < `EPA_MAX_LINE; k++) begin
				ld_nxt[k*`EPA_WORD_W +: `EPA_WORD_W] =
					(3'(k) < head_len) ? q_r[k] : '0;
			end
		end
		mac_d_nxt = sv_r[7] && mac_r[7];
	end
	// Commit after compute2 so older lines read prior values
	assign wb_commit_out = sv_r[7] && !mac_r[7];
	assign wb_reg_out = dst_r[7];
	assign acc_commit_out = mac_d_r;
	assign stage_valid_out = sv_r;
	assign line_valid_out = lv_r;
	assign line_data_out = ld_r;
	assign line_len_out = ll_r;
	assign line_pc_out = lpc_r;

	////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < `EPA_Q_WORDS; i++) begin
				q_r[i] <= '0;
			end
			for (int s = 3; s <= 7; s++) begin
				dst_r[s] <= '0;
			end
			cnt_r <= '0;
			pc_r <= '0;
			faddr_r <= '0;
			fs_r <= EPA_FS_IDLE;
			gap_r <= '0;
			out_r <= '0;
			drop_r <= '0;
			sv_r <= '0;
			late_r <= '0;
			mac_r <= '0;
			mac_d_r <= 1'b0;
			ld_r <= '0;
			ll_r <= '0;
			lpc_r <= '0;
			lv_r <= 1'b0;
		end else begin
			for (int i = 0; i < `EPA_Q_WORDS; i++) begin
				q_r[i] <= q_nxt[i];
			end
			for (int s = 3; s <= 7; s++) begin
				dst_r[s] <= dst_nxt[s];
			end
			cnt_r <= cnt_nxt;
			pc_r <= pc_nxt;
			faddr_r <= faddr_nxt;
			fs_r <= fs_nxt;
			gap_r <= gap_nxt;
			out_r <= out_nxt;
			drop_r <= drop_nxt;
			sv_r <= sv_nxt;
			late_r <= late_nxt;
			mac_r <= mac_nxt;
			mac_d_r <= mac_d_nxt;
			ld_r <= ld_nxt;
			ll_r <= ll_nxt;
			lpc_r <= lpc_nxt;
			lv_r <= lv_nxt;
		end
	end
endmodule
`default_nettype wire

// *** tb/epa_pipe_chk_sva.sv ***
// Port checker for the eight-stage pipe
`include "epa_defs.svh"
`default_nettype none
module epa_pipe_chk (
	// Clock, reset and fetch side
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic fetch_req_out,
	input wire logic [`EPA_ADDR_W-1:0] fetch_addr_out,
	input wire logic fetch_ext_in,
	input wire logic fetch_valid_in,
	input wire logic sclk_en_in,
	input wire logic flow_taken_in,
	// Issue and pipe status
	input wire logic line_valid_out,
	input wire logic [`EPA_QUAD_W-1:0] line_data_out,
	input wire logic [2:0] line_len_out,
	input wire logic [7:0] stage_valid_out,
	input wire logic stall_out,
	input wire logic wb_commit_out,
	input wire logic acc_commit_out
);
	// Word count lags the design by one pull, so limits carry slack
	logic [5:0] cnt_r, cnt_nxt;
	logic [1:0] gap_r, gap_nxt;
	logic ends_ok;
	always_comb begin
		cnt_nxt = cnt_r - (line_valid_out ? {3'h0, line_len_out} : 6'h00);
		if (flow_taken_in)
			cnt_nxt = 6'h00;
		if (fetch_req_out)
			cnt_nxt = cnt_nxt + 6'h04;
		gap_nxt = gap_r + {1'h0, sclk_en_in && gap_r != 2'h2};
		if (fetch_ext_in && (fetch_req_out || fetch_valid_in))
			gap_nxt = 2'h0;
		ends_ok = 1'h1;
		for (int i = 0; i < 4; i++)
			if (i < line_len_out)
				ends_ok &= line_data_out[32*i+31] == (i + 1 < line_len_out);
			else
				ends_ok &= line_data_out[32*i+:32] == 32'h0;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 6'h00;
			gap_r <= 2'h2;
		end else begin
			cnt_r <= cnt_nxt;
			gap_r <= gap_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_bubble;
		!stage_valid_out[6] && $stable(stage_valid_out[5:3]);
	endsequence
	AST_DEPTH: assert property (cnt_r <= 6'h14)
		else $error("align queue over five quads");
	AST_REFILL: assert property (cnt_r < 6'h08 && !fetch_ext_in
		&& !flow_taken_in |-> ##[0:8] fetch_req_out)
		else $error("fetch idle with room");
	AST_EXT_PACE: assert property (fetch_req_out && fetch_ext_in
		|-> gap_r == 2'h2)
		else $error("external fetch too fast");
	AST_NEXT_QUAD: assert property (fetch_req_out && !flow_taken_in
		|=> fetch_addr_out == $past(fetch_addr_out) + `EPA_QUAD_INC)
		else $error("fetch address not next quad");
	AST_SHAPE: assert property (line_valid_out |-> ends_ok
		&& line_len_out inside {[3'h1:3'h4]})
		else $error("bad line shape");
	AST_REFUSE: assert property (stall_out || flow_taken_in
		|=> !line_valid_out)
		else $error("line issued while refused");
	AST_HOLD: assert property (stall_out |=> s_bubble)
		else $error("stall did not hold stages");
	AST_ADVANCE: assert property (stage_valid_out[6] |=> stage_valid_out[7])
		else $error("compute stage did not advance");
	AST_MAC: assert property (acc_commit_out |-> $past(stage_valid_out[7])
		&& !$past(wb_commit_out))
		else $error("accumulator commit without mac line");
endmodule
`default_nettype wire

// *** tb/epa_imem.sv ***
// Instruction memory model for the fetch port
`default_nettype none
module epa_imem (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_in,
	input wire logic [31:0] addr_in,
	input wire logic ext_in,
	input wire logic sclk_en_in,
	input wire logic [1:0] lat_in,
	output logic valid_out,
	output logic [127:0] data_out
);
	logic [31:0] pend[$], a;
	int wait_c = 0;
	// Lines of 1, 2, 3 and 4 words repeat every ten words, no stores
	function automatic logic [31:0] word_at(input logic [31:0] b);
		int p;
		p = b[31:2] % 10;
		return {p != 0 && p != 2 && p != 5 && p != 9, 1'h0, b[31:2]};
	endfunction
	initial valid_out = 1'h0;
	initial data_out = '0;
	always @(posedge clk_in) begin
		valid_out <= 1'h0;
		data_out <= ~data_out;
		if (!rst_n_in)
			pend.delete();
		else begin
			if (req_in)
				pend.push_back(addr_in);
			if (wait_c > 0)
				wait_c--;
			else if (pend.size() > 0 && (!ext_in || sclk_en_in)) begin
				a = pend.pop_front();
				valid_out <= 1'h1;
				for (int k = 0; k < 4; k++)
					data_out[32*k+:32] <= word_at(a + 4 * k);
				wait_c = lat_in + (ext_in ? 2 : 0);
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/epa_pipe_tb.sv ***
// Self-checking bench for the eight-stage pipe
`default_nettype none
module epa_pipe_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [127:0] d;
		logic [2:0] n;
		logic [31:0] pc;
	} epa_exp_t;
	logic clk_in = 1'h0, rst_n_in = 1'h0, fetch_ext_in = 1'h0, rnd = 1'h0;
	logic sclk_en_in = 1'h0, flow_taken_in = 1'h0, dec_src_used_in = 1'h0;
	logic dec_late_in = 1'h0, dec_mac_in = 1'h0, acc_grant_in = 1'h1;
	logic fetch_req_out, fetch_valid_in, line_valid_out, stall_out;
	logic wb_commit_out, acc_commit_out;
	logic [31:0] fetch_addr_out, flow_target_in = '0, line_pc_out;
	logic [127:0] fetch_data_in, line_data_out;
	logic [4:0] dec_src_reg_in = '0, dec_dst_reg_in = '0, wb_reg_out;
	logic [2:0] line_len_out;
	logic [7:0] stage_valid_out;
	logic [1:0] lat = '0;
	// Destination and mac flag of each issued line, oldest first
	logic [5:0] dp = '0, dn;
	logic [5:0] dq[$];
	int failures = 0, comparisons = 0, seed = 32'h8DA2;
	epa_exp_t notes[$], e;
	epa_pipe epa_pipe_inst (.*);
	epa_imem epa_imem_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.req_in(fetch_req_out), .addr_in(fetch_addr_out),
		.ext_in(fetch_ext_in), .sclk_en_in(sclk_en_in), .lat_in(lat),
		.valid_out(fetch_valid_in), .data_out(fetch_data_in));
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	always @(posedge clk_in) sclk_en_in <= ~sclk_en_in;
	always @(posedge clk_in) dp <= {dec_mac_in, dec_dst_reg_in};
	////////////////////////////////////////////////////////////////////
	task automatic plan(input logic [31:0] a, input int n);
		epa_exp_t x;
		logic [31:0] w;
		repeat (n) begin
			x.d = '0;
			x.n = '0;
			x.pc = a;
			do begin
				w = epa_imem_inst.word_at(a);
				x.d[32*x.n+:32] = w;
				x.n++;
				a += 4;
			end while (w[31]);
			notes.push_back(x);
		end
	endtask
	task automatic jump(input logic [31:0] t, input logic ext);
		@(posedge clk_in);
		#1 flow_taken_in = 1'h1;
		flow_target_in = t;
		@(posedge clk_in);
		#1 flow_taken_in = 1'h0;
		fetch_ext_in = ext;
		notes.delete();
		plan(t, 400);
	endtask
	task automatic run(input int n, input int least, input string name);
		int c0;
		c0 = comparisons;
		repeat (n) begin
			@(posedge clk_in);
			#1 lat = 2'($random(seed));
			if (rnd) begin
				dec_src_reg_in = {3'h0, 2'($random(seed))};
				dec_dst_reg_in = {3'h0, 2'($random(seed))};
				{dec_src_used_in, dec_late_in, dec_mac_in} = 3'($random(seed));
			end
		end
		if (comparisons - c0 < least) begin
			failures++;
			$display("unexpected %s lines: expected %0d seen %0d", name,
				least, comparisons - c0);
		end
		$display("test %s done", name);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(negedge clk_in) begin
		if (line_valid_out === 1'h1) begin
			comparisons++;
			e = notes.size() > 0 ? notes.pop_front() : '{'1, '1, '1};
			if ({line_data_out, line_len_out, line_pc_out} !== {e.d, e.n, e.pc}) begin
				failures++;
				$display("unexpected line: expected %h %h seen %h %h", e.pc,
					e.d, line_pc_out, line_data_out);
			end
			dq.push_back(dp);
		end
		if (stage_valid_out[7] === 1'h1) begin
			comparisons++;
			dn = dq.size() > 0 ? dq.pop_front() : 6'h3F;
			if ({!dn[5], dn[4:0]} !== {wb_commit_out, wb_reg_out}) begin
				failures++;
				$display("unexpected write-back: expected %b %h seen %b %h",
					!dn[5], dn[4:0], wb_commit_out, wb_reg_out);
			end
		end
	end
	initial begin
		plan(32'h0, 400);
		repeat (2) @(posedge clk_in);
		#1 rst_n_in = 1'h1;
		run(100, 20, "plain");
		rnd = 1'h1;
		jump(32'h34, 1'h0);
		run(200, 10, "hazard");
		jump(32'h18, 1'h0);
		jump(32'h64, 1'h0);
		run(60, 5, "flush");
		jump(32'h100, 1'h1);
		run(300, 5, "external");
		jump(32'h0, 1'h0);
		acc_grant_in = 1'h0;
		run(40, 0, "held");
		acc_grant_in = 1'h1;
		run(60, 5, "release");
		give_verdict();
	end
endmodule
bind epa_pipe epa_pipe_chk epa_pipe_chk_inst (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.fetch_req_out(fetch_req_out),
	.fetch_addr_out(fetch_addr_out),
	.fetch_ext_in(fetch_ext_in),
	.fetch_valid_in(fetch_valid_in),
	.sclk_en_in(sclk_en_in),
	.flow_taken_in(flow_taken_in),
	.line_valid_out(line_valid_out),
	.line_data_out(line_data_out),
	.line_len_out(line_len_out),
	.stage_valid_out(stage_valid_out),
	.stall_out(stall_out),
	.wb_commit_out(wb_commit_out),
	.acc_commit_out(acc_commit_out)
);
`default_nettype wire
